// ===== oppx_pkg.sv
//==============================================================
// Function
// RL1: Register OR writes first source OR second source to destination, no exception.
// RL2: Constant OR zero-extends 16-bit constant, ORs with source, writes target.
// RL3: Lock-wait with flag set deschedules, resumes at address plus 4 when clear.
// RL4: Single-threaded core may also end the wait on an external event.
// RL5: Store by another thread clears the linked-load flag, releasing the wait.
// RL6: Without lock-wait support the encoding executes as a no-operation.
// RL7: Software keeps the lock-wait hint out of branch delay slots.
// RL8: Lower-lower merge: upper half first source 31..0, lower half second 31..0.
// RL9: Lower-upper merge: upper half first source 31..0, lower half second 63..32.
// RL10: Merges are pure bit moves raising no arithmetic floating-point exceptions.
// RL11: Merge result defined only on 64-bit unit in 64-bit register model.
// RL12: Merges raise only coprocessor-unusable or reserved-instruction exceptions.
// RL13: Prefetch address is base plus sign-extended 16-bit offset; hint passed on.
// RL14: Prefetch changes no visible state except the line-zero-allocate hint.
// RL15: Prefetch never raises address faults; faulting address moves no data.
// RL16: Faulted prefetch may still do invisible actions such as dirty writeback.
// RL17: Bus or cache error reporting from prefetch is an implementation choice.
// RL18: Prefetch to uncached location issues nothing and leaves lines unchanged.
// RL19: Prefetch memory operation uses the address's access type and attribute.
// RL20: Cached prefetch fetches a block holding the address; size is our choice.
// RL21: Coherent attribute makes the prefetch a coherent memory transaction.
// RL22: Prefetch and its transactions obey memory barrier ordering rules.
// RL23: Hint 0 load, 1 store, 25 writeback-invalidate, 30 zero-allocate line.
// RL24: Prefetch leaves previously locked cache lines unaffected.
//==============================================================
package oppx_pkg;
	localparam int          XLEN        = 32;
	localparam int          IMM_W       = 16;
	localparam int          HINT_W      = 5;
	localparam logic [31:0] PC_STEP     = 32'h0000_0004;
	localparam logic [4:0]  HINT_LOAD   = 5'h00;
	localparam logic [4:0]  HINT_STORE  = 5'h01;
	localparam logic [4:0]  HINT_WBINV  = 5'h19;
	localparam logic [4:0]  HINT_ZALLOC = 5'h1e;

	typedef enum logic [2:0] {
		OPPX_NONE, OPPX_OR, OPPX_ORC, OPPX_PAUSE, OPPX_PLL, OPPX_PLU, OPPX_PREFETCH_OP
	} oppx_op_t;

	typedef enum logic [1:0] {
		OPPX_PF_LOAD, OPPX_PF_STORE, OPPX_PF_WBINV, OPPX_PF_ZALLOC
	} oppx_pf_kind_t;

	typedef enum {OPPX_RUN, OPPX_WAIT} oppx_st_t;

	// One issued operation with its operands
	typedef struct packed {
		logic              valid;
		oppx_op_t          op;
		logic [31:0]       pc;
		logic [XLEN-1:0]   src_a;
		logic [XLEN-1:0]   src_b;
		logic [IMM_W-1:0]  imm;
		logic [HINT_W-1:0] hint;
		logic [63:0]       fsrc_a;
		logic [63:0]       fsrc_b;
	} oppx_req_t;

	// Translation result for a prefetch address
	typedef struct packed {
		logic fault;
		logic uncached;
		logic coherent;
		logic locked;
	} oppx_attr_t;

	// Prefetch request to the cache
	typedef struct packed {
		logic              valid;
		logic [XLEN-1:0]   addr;
		logic [HINT_W-1:0] hint;
		oppx_pf_kind_t     kind;
		logic              coherent;
		logic              barrier;
	} oppx_pf_t;
endpackage : oppx_pkg

// ===== oppx_core.sv
`timescale 1ns/1ns
module oppx_core #(
	parameter bit PAUSE_IMPL    = 1'b1,
	parameter bit SINGLE_THREAD = 1'b1
) (
	input  wire logic               core_clk_i,
	input  wire logic               rstn_i,
	input  wire oppx_pkg::oppx_req_t req_i,
	input  wire logic               ll_flag_i,
	input  wire logic               ext_event_i,
	input  wire logic               remote_store_i,
	input  wire logic               fp_model64_i,
	input  wire logic               fpu_off_i,
	input  wire logic               fpu_absent_i,
	input  wire oppx_pkg::oppx_attr_t attr_i,
	input  wire logic               pf_ready_i,
	output logic                    gpr_we_o,
	output logic [oppx_pkg::XLEN-1:0] gpr_wdata_o,
	output logic                    fpr_we_o,
	output logic [63:0]             fpr_wdata_o,
	output logic                    cop_unusable_o,
	output logic                    reserved_instr_o,
	output logic                    stall_o,
	output logic                    resume_o,
	output logic [31:0]             resume_pc_o,
	output oppx_pkg::oppx_pf_t      pf_o
);

	//==========================================================
	// State
	//==========================================================
	typedef struct packed {
		oppx_pkg::oppx_st_t st;
		logic               gpr_we;
		logic [oppx_pkg::XLEN-1:0] gpr_wdata;
		logic               fpr_we;
		logic [63:0]        fpr_wdata;
		logic               cpu_exc;
		logic               ri_exc;
		logic               stall;
		logic               resume;
		logic [31:0]        resume_pc;
		oppx_pkg::oppx_pf_t pf;
		logic               ext_s1;
		logic               ext_s2;
		logic               ll_s1;
		logic               ll_s2;
	} oppx_state_t;

	oppx_state_t s_q;
	oppx_state_t s_d;
	logic        flag_set;
	logic        take;
	logic [oppx_pkg::XLEN-1:0] ea;

	//==========================================================
	// Elaboration checks
	//==========================================================
	// Result and address paths assume a 32-bit register and a narrower
	// constant field; other widths would truncate without a warning
	if (oppx_pkg::XLEN != 32 || oppx_pkg::IMM_W >= oppx_pkg::XLEN
		|| oppx_pkg::HINT_W != 5)
	begin : g_width_check
		$error("Unsupported operand widths");
	end

	// A request is taken only in RUN with no blocked prefetch ahead
	assign take = req_i.valid && s_q.st == oppx_pkg::OPPX_RUN
		&& !(s_q.pf.valid && !pf_ready_i);

	// Flag seen by this thread; a remote store clears it at once
	assign flag_set = s_q.ll_s2 && !remote_store_i; // [RL5]
	// Sign-extended offset plus base
	assign ea = req_i.src_a
		+ {{(oppx_pkg::XLEN-oppx_pkg::IMM_W){req_i.imm[oppx_pkg::IMM_W-1]}},
		req_i.imm}; // [RL13]

	//==========================================================
	// Next state
	//==========================================================
	// Only the prefetch waits for the cache and a pause with the flag set waits for release; everything else is one cycle
	always_comb
	begin
		s_d           = s_q;
		s_d.ext_s1    = ext_event_i;
		s_d.ext_s2    = s_q.ext_s1;
		s_d.ll_s1     = ll_flag_i;
		s_d.ll_s2     = s_q.ll_s1;
		s_d.gpr_we    = 1'b0;
		s_d.fpr_we    = 1'b0;
		s_d.cpu_exc   = 1'b0;
		s_d.ri_exc    = 1'b0;
		s_d.resume    = 1'b0;
		if (s_q.pf.valid && pf_ready_i)
			s_d.pf.valid = 1'b0;
		unique case (s_q.st)
			oppx_pkg::OPPX_WAIT:
			begin
				// Release on flag clear, or on an event if single-threaded
				if (!flag_set || (SINGLE_THREAD && s_q.ext_s2)) // [RL3] [RL4]
				begin
					s_d.st     = oppx_pkg::OPPX_RUN;
					s_d.stall  = 1'b0;
					s_d.resume = 1'b1;
				end
			end
			oppx_pkg::OPPX_RUN:
			begin
				if (req_i.valid && !(s_q.pf.valid && !pf_ready_i))
				begin
					unique case (req_i.op)
						oppx_pkg::OPPX_OR:
						begin
							s_d.gpr_we    = 1'b1;
							s_d.gpr_wdata = req_i.src_a | req_i.src_b; // [RL1]
						end
						oppx_pkg::OPPX_ORC:
						begin
							s_d.gpr_we    = 1'b1;
							s_d.gpr_wdata = req_i.src_a
								| {{(oppx_pkg::XLEN-oppx_pkg::IMM_W){1'b0}},
								req_i.imm}; // [RL2]
						end
						oppx_pkg::OPPX_PAUSE:
						begin
							// Unimplemented: plain no-operation
							if (PAUSE_IMPL && flag_set) // [RL6]
							begin
								s_d.st        = oppx_pkg::OPPX_WAIT;
								s_d.stall     = 1'b1;
								s_d.resume_pc = req_i.pc + oppx_pkg::PC_STEP; // [RL3]
							end
						end
						oppx_pkg::OPPX_PLL,
						oppx_pkg::OPPX_PLU:
						begin
							// Only these two faults; no arithmetic flags exist
							if (fpu_absent_i)
								s_d.ri_exc = 1'b1; // [RL12]
							else if (fpu_off_i)
								s_d.cpu_exc = 1'b1; // [RL12]
							else
							begin
								// Written regardless of model; defined in 64-bit
								s_d.fpr_we = 1'b1; // [RL11]
								s_d.fpr_wdata = (req_i.op == oppx_pkg::OPPX_PLL)
									? {req_i.fsrc_a[31:0], req_i.fsrc_b[31:0]} // [RL8] [RL10]
									: {req_i.fsrc_a[31:0], req_i.fsrc_b[63:32]}; // [RL9]
							end
						end
						oppx_pkg::OPPX_PREFETCH_OP:
						begin
							// Faults, uncached and locked lines: silently dropped
							// No hidden writeback is started for them [RL16]
							if (!attr_i.fault && !attr_i.uncached // [RL15] [RL18]
								&& !attr_i.locked) // [RL24]
							begin
								s_d.pf.addr     = ea; // [RL20]
								s_d.pf.hint     = req_i.hint;
								s_d.pf.coherent = attr_i.coherent; // [RL19] [RL21]
								s_d.pf.barrier  = 1'b1; // [RL22]
								s_d.pf.valid    = 1'b1;
								unique case (req_i.hint)
									oppx_pkg::HINT_STORE:  s_d.pf.kind = oppx_pkg::OPPX_PF_STORE;
									oppx_pkg::HINT_WBINV:  s_d.pf.kind = oppx_pkg::OPPX_PF_WBINV;
									oppx_pkg::HINT_ZALLOC: s_d.pf.kind = oppx_pkg::OPPX_PF_ZALLOC; // [RL14]
									default:               s_d.pf.kind = oppx_pkg::OPPX_PF_LOAD; // [RL23]
								endcase
							end
						end
						default:
						begin
						end
					endcase
				end
			end
		endcase
		// Bus and cache errors from prefetch are never reported here [RL17]
	end

	//==========================================================
	// Registers
	//==========================================================
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign gpr_we_o         = s_q.gpr_we;
	assign gpr_wdata_o      = s_q.gpr_wdata;
	assign fpr_we_o         = s_q.fpr_we;
	assign fpr_wdata_o      = s_q.fpr_wdata;
	assign cop_unusable_o   = s_q.cpu_exc;
	assign reserved_instr_o = s_q.ri_exc;
	assign stall_o          = s_q.stall;
	assign resume_o         = s_q.resume;
	assign resume_pc_o      = s_q.resume_pc;
	assign pf_o             = s_q.pf;

	//==========================================================
	// Checks
	//==========================================================
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	sequence or_issue_s;
		req_i.valid && req_i.op == oppx_pkg::OPPX_OR && s_q.st == oppx_pkg::OPPX_RUN
		&& !(s_q.pf.valid && !pf_ready_i);
	endsequence

	or_result_a: assert property (or_issue_s |=> gpr_we_o // [RL1]
		&& gpr_wdata_o == ($past(req_i.src_a) | $past(req_i.src_b)))
		else $error("OR result wrong");

	orc_zero_ext_a: assert property (req_i.valid && req_i.op == oppx_pkg::OPPX_ORC
		&& s_q.st == oppx_pkg::OPPX_RUN && !(s_q.pf.valid && !pf_ready_i)
		|=> gpr_wdata_o[31:16] == $past(req_i.src_a[31:16])) // [RL2]
		else $error("Constant OR upper half wrong");

	pause_resume_pc_a: assert property ($rose(stall_o)
		|-> resume_pc_o == $past(req_i.pc) + 32'h0000_0004) // [RL3]
		else $error("Resume address wrong");

	pause_release_a: assert property (stall_o && !flag_set
		|=> !stall_o && resume_o) // [RL5]
		else $error("Wait not released");

	pll_merge_a: assert property (s_q.st == oppx_pkg::OPPX_RUN && req_i.valid
		&& req_i.op == oppx_pkg::OPPX_PLL && !fpu_off_i && !fpu_absent_i
		&& !(s_q.pf.valid && !pf_ready_i)
		|=> fpr_we_o && fpr_wdata_o[31:0] == $past(req_i.fsrc_b[31:0])) // [RL8]
		else $error("Lower-lower merge wrong");

	plu_merge_a: assert property (s_q.st == oppx_pkg::OPPX_RUN && req_i.valid
		&& req_i.op == oppx_pkg::OPPX_PLU && !fpu_off_i && !fpu_absent_i
		&& !(s_q.pf.valid && !pf_ready_i)
		|=> fpr_wdata_o == {$past(req_i.fsrc_a[31:0]),
		$past(req_i.fsrc_b[63:32])}) // [RL9]
		else $error("Lower-upper merge wrong");

	merge_exc_a: assert property (fpr_we_o |-> !cop_unusable_o && !reserved_instr_o) // [RL12]
		else $error("Merge wrote and faulted");

	pf_drop_a: assert property (s_q.st == oppx_pkg::OPPX_RUN && req_i.valid
		&& req_i.op == oppx_pkg::OPPX_PREFETCH_OP && (attr_i.fault || attr_i.uncached)
		&& !s_q.pf.valid |=> !pf_o.valid) // [RL18]
		else $error("Prefetch not dropped");

	pf_hold_a: assert property (pf_o.valid && !pf_ready_i
		|=> pf_o.valid && $stable(pf_o.addr)) // [RL22]
		else $error("Prefetch request lost");

	//==========================================================
	// Sequences for the multi-step checks
	//==========================================================
	sequence pause_issue_s;
		take && req_i.op == oppx_pkg::OPPX_PAUSE;
	endsequence

	sequence merge_issue_s;
		take && (req_i.op == oppx_pkg::OPPX_PLL
		|| req_i.op == oppx_pkg::OPPX_PLU);
	endsequence

	sequence pf_issue_s;
		take && req_i.op == oppx_pkg::OPPX_PREFETCH_OP;
	endsequence

	// A prefetch that survives the translation filter
	sequence pf_clean_s;
		pf_issue_s ##0 (!attr_i.fault && !attr_i.uncached
		&& !attr_i.locked);
	endsequence

	pause_enter_a: assert property (pause_issue_s ##0 flag_set // [RL3]
		|=> stall_o && !resume_o)
		else $error("Wait not entered");

	pause_nop_a: assert property (pause_issue_s ##0 !flag_set // [RL6]
		|=> !stall_o && !gpr_we_o && !fpr_we_o)
		else $error("Pause without flag not a no-operation");

	event_wake_a: assert property (stall_o && SINGLE_THREAD // [RL4]
		&& s_q.ext_s2 |=> !stall_o && resume_o)
		else $error("Event did not end the wait");

	remote_clear_a: assert property (stall_o && remote_store_i // [RL5]
		|=> !stall_o && resume_o)
		else $error("Remote store did not release");

	wait_quiet_a: assert property (stall_o // [RL3]
		|-> !gpr_we_o && !fpr_we_o)
		else $error("Result written while waiting");

	orc_low_a: assert property (take && req_i.op == oppx_pkg::OPPX_ORC // [RL2]
		|=> gpr_wdata_o[15:0]
		== ($past(req_i.src_a[15:0]) | $past(req_i.imm)))
		else $error("Constant OR lower half wrong");

	pll_upper_a: assert property (take && req_i.op == oppx_pkg::OPPX_PLL // [RL8]
		&& !fpu_off_i && !fpu_absent_i
		|=> fpr_wdata_o[63:32] == $past(req_i.fsrc_a[31:0]))
		else $error("Lower-lower upper half wrong");

	merge_absent_a: assert property (merge_issue_s ##0 fpu_absent_i // [RL12]
		|=> reserved_instr_o && !cop_unusable_o && !fpr_we_o)
		else $error("Missing unit not reported");

	merge_off_a: assert property (merge_issue_s // [RL12]
		##0 (fpu_off_i && !fpu_absent_i)
		|=> cop_unusable_o && !reserved_instr_o && !fpr_we_o)
		else $error("Disabled unit not reported");

	merge_model_a: assert property (merge_issue_s // [RL11]
		##0 (fp_model64_i && !fpu_off_i && !fpu_absent_i)
		|=> fpr_we_o)
		else $error("Merge not written in 64-bit model");

	pf_issue_a: assert property (pf_clean_s // [RL13] [RL22]
		|=> pf_o.valid && pf_o.addr == $past(ea) && pf_o.barrier)
		else $error("Prefetch request malformed");

	pf_coh_a: assert property (pf_clean_s // [RL19] [RL21]
		|=> pf_o.coherent == $past(attr_i.coherent)
		&& pf_o.hint == $past(req_i.hint))
		else $error("Prefetch attribute not passed on");

	pf_locked_a: assert property (pf_issue_s ##0 attr_i.locked // [RL24]
		|=> !pf_o.valid)
		else $error("Locked line touched");

	pf_quiet_a: assert property (pf_issue_s // [RL14] [RL15]
		|=> !gpr_we_o && !fpr_we_o && !cop_unusable_o
		&& !reserved_instr_o)
		else $error("Prefetch changed visible state");

	pf_zalloc_a: assert property (pf_clean_s // [RL23]
		##0 req_i.hint == oppx_pkg::HINT_ZALLOC
		|=> pf_o.kind == oppx_pkg::OPPX_PF_ZALLOC)
		else $error("Zero-allocate kind wrong");

	pf_wbinv_a: assert property (pf_clean_s // [RL23]
		##0 req_i.hint == oppx_pkg::HINT_WBINV
		|=> pf_o.kind == oppx_pkg::OPPX_PF_WBINV)
		else $error("Writeback-invalidate kind wrong");

	pf_store_a: assert property (pf_clean_s // [RL23]
		##0 req_i.hint == oppx_pkg::HINT_STORE
		|=> pf_o.kind == oppx_pkg::OPPX_PF_STORE)
		else $error("Store kind wrong");
endmodule : oppx_core

// ===== oppx_cache_model.sv
`timescale 1ns/1ns
//==============================================================
// Cache side model: takes prefetch requests, fast or slow
module oppx_cache_model (
	input  wire logic               core_clk_i,
	input  wire logic               rstn_i,
	input  wire oppx_pkg::oppx_pf_t pf_i,
	input  wire logic               slow_i,
	output logic                    ready_o,
	output logic                    acc_o,
	output int                      coh_o
);
	logic [1:0] cnt_q;

	// Slow mode is ready one edge in four, so the issuer must hold
	always_ff @(posedge core_clk_i)
	begin
		cnt_q   <= rstn_i ? cnt_q + 2'h1 : 2'h0;
		ready_o <= rstn_i && (!slow_i || cnt_q == 2'h2);
		if (!rstn_i)
			coh_o <= 0;
		else if (acc_o && pf_i.coherent)
			coh_o <= coh_o + 1;
	end

	// A request is taken where valid meets ready at an edge
	assign acc_o = pf_i.valid && ready_o;
endmodule : oppx_cache_model

// ===== or_pause_pairmerge_prefetch_exec_bench.sv
`timescale 1ns/1ns
module or_pause_pairmerge_prefetch_exec_bench;
	logic                 core_clk_i = 1'b0;
	logic                 rstn_i     = 1'b0;
	oppx_pkg::oppx_req_t  req_i      = '0;
	oppx_pkg::oppx_req_t  r;
	oppx_pkg::oppx_attr_t attr_i     = '0;
	oppx_pkg::oppx_attr_t a;
	oppx_pkg::oppx_pf_t   e;
	oppx_pkg::oppx_pf_t   pf_o;
	oppx_pkg::oppx_pf_t   exp_q[$];
	logic ll_flag_i = 1'b0, ext_event_i = 1'b0, remote_store_i = 1'b0;
	logic fp_model64_i = 1'b1, fpu_off_i = 1'b0, fpu_absent_i = 1'b0;
	logic slow_i = 1'b0, pf_ready_i, acc, gpr_we_o, fpr_we_o;
	logic cop_unusable_o, reserved_instr_o, stall_o, resume_o;
	logic [31:0] gpr_wdata_o, resume_pc_o;
	logic [63:0] fpr_wdata_o;
	logic [4:0]  hints[5] = '{5'h00, 5'h01, 5'h19, 5'h1e, 5'h07};
	int fail_count = 0, tests_run = 0, seed = 32'he0cc;
	int coh_seen, coh_exp = 0, i, k, n;

	always #20 core_clk_i = ~core_clk_i;

	oppx_core oppx_core_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.req_i(req_i), .ll_flag_i(ll_flag_i), .ext_event_i(ext_event_i),
		.remote_store_i(remote_store_i), .fp_model64_i(fp_model64_i),
		.fpu_off_i(fpu_off_i), .fpu_absent_i(fpu_absent_i), .attr_i(attr_i),
		.pf_ready_i(pf_ready_i), .gpr_we_o(gpr_we_o),
		.gpr_wdata_o(gpr_wdata_o), .fpr_we_o(fpr_we_o),
		.fpr_wdata_o(fpr_wdata_o), .cop_unusable_o(cop_unusable_o),
		.reserved_instr_o(reserved_instr_o), .stall_o(stall_o),
		.resume_o(resume_o), .resume_pc_o(resume_pc_o), .pf_o(pf_o));

	oppx_cache_model oppx_cache_model_inst (.core_clk_i(core_clk_i),
		.rstn_i(rstn_i), .pf_i(pf_o), .slow_i(slow_i),
		.ready_o(pf_ready_i), .acc_o(acc), .coh_o(coh_seen));

	//==============================================================
	// Shared tasks
	task check(input string nm, input logic [63:0] s, input logic [63:0] x);
		tests_run++;
		if (s !== x)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
	endtask : check

	task test_done;
		$display("Checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// A wait that ran out counts as a mismatch and ends the run
	task over(input int lim);
		if (n >= lim)
		begin
			fail_count++;
			test_done();
		end
	endtask : over

	// Request stands for one edge, outputs read once they land
	task issue(input oppx_pkg::oppx_req_t q);
		@(posedge core_clk_i);
		req_i <= q;
		@(posedge core_clk_i);
		req_i.valid <= 1'b0;
		#1;
	endtask : issue

	// Accepted prefetches are matched against the queued model
	always @(negedge core_clk_i)
	begin
		if (rstn_i && acc && exp_q.size() == 0)
			check("pf extra", 1, 0);
		else if (rstn_i && acc)
			check("pf_o", pf_o, exp_q.pop_front());
	end

	//==============================================================
	// Main sequence
	initial
	begin
		repeat (6) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		for (i = 0; i < 40; i++)
		begin
			r = '0;
			r.valid = 1'b1;
			r.op = oppx_pkg::oppx_op_t'(i % 4 < 2 ? 1 + i % 4 : 2 + i % 4);
			r.src_a = $random(seed);
			r.src_b = $random(seed);
			r.imm = $random(seed);
			r.fsrc_a = {$random(seed), $random(seed)};
			r.fsrc_b = {$random(seed), $random(seed)};
			fp_model64_i <= i[2];
			issue(r);
			k = (r.op == oppx_pkg::OPPX_OR || r.op == oppx_pkg::OPPX_ORC);
			check("gpr_we", gpr_we_o, k);
			check("fpr_we", fpr_we_o, !k);
			if (r.op == oppx_pkg::OPPX_OR)
				check("or", gpr_wdata_o, r.src_a | r.src_b);
			else if (k)
				check("orc", gpr_wdata_o, r.src_a | {16'h0, r.imm});
			else
				check("merge", fpr_wdata_o, {r.fsrc_a[31:0],
					r.op == oppx_pkg::OPPX_PLL ? r.fsrc_b[31:0]
					: r.fsrc_b[63:32]});
			check("exc", {cop_unusable_o, reserved_instr_o}, 0);
		end
		fpu_off_i <= 1'b1;
		issue(r);
		check("cop", {cop_unusable_o, reserved_instr_o, fpr_we_o}, 4);
		fpu_absent_i <= 1'b1;
		issue(r);
		check("resv", {cop_unusable_o, reserved_instr_o, fpr_we_o}, 2);
		fpu_off_i <= 1'b0;
		fpu_absent_i <= 1'b0;
		$display("Test ops done");
		// Pause issued outside any branch shadow
		for (k = 0; k < 3; k++)
		begin
			ll_flag_i <= 1'b1;
			repeat (3) @(posedge core_clk_i);
			r = '0;
			r.valid = 1'b1;
			r.op = oppx_pkg::OPPX_PAUSE;
			r.pc = $random(seed) & 32'hffff_fffc;
			issue(r);
			check("stall", stall_o, 1);
			check("pc", resume_pc_o, r.pc + oppx_pkg::PC_STEP);
			r.op = oppx_pkg::OPPX_OR;
			issue(r);
			check("refused", {gpr_we_o, stall_o}, 1);
			ll_flag_i <= k != 0;
			ext_event_i <= k == 1;
			remote_store_i <= k == 2;
			@(posedge core_clk_i);
			ext_event_i <= 1'b0;
			remote_store_i <= 1'b0;
			#1;
			for (n = 0; n < 20 && resume_o !== 1'b1; n++)
			begin
				@(posedge core_clk_i);
				#1;
			end
			over(20);
			check("wake", {stall_o, resume_pc_o}, r.pc + 4);
		end
		ll_flag_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		r.op = oppx_pkg::OPPX_PAUSE;
		issue(r);
		check("no wait", stall_o, 0);
		$display("Test pause done");
		for (i = 0; i < 30; i++)
		begin
			slow_i <= i[1];
			a = $random(seed);
			a = i[0] ? a & 4'h2 : a;
			r = '0;
			r.valid = 1'b1;
			r.op = oppx_pkg::OPPX_PREFETCH_OP;
			r.src_a = $random(seed);
			r.imm = $random(seed);
			r.hint = hints[i % 5];
			e = '0;
			e.valid = 1'b1;
			e.addr = r.src_a + {{16{r.imm[15]}}, r.imm};
			e.hint = r.hint;
			e.kind = r.hint == 5'h01 ? oppx_pkg::OPPX_PF_STORE
				: r.hint == 5'h19 ? oppx_pkg::OPPX_PF_WBINV
				: r.hint == 5'h1e ? oppx_pkg::OPPX_PF_ZALLOC
				: oppx_pkg::OPPX_PF_LOAD;
			e.coherent = a.coherent;
			e.barrier = 1'b1;
			k = !(a.fault || a.uncached || a.locked);
			if (k)
				exp_q.push_back(e);
			coh_exp += k && a.coherent;
			attr_i <= a;
			issue(r);
			check("pf drop", pf_o.valid, k);
			check("pf quiet", {gpr_we_o, fpr_we_o, cop_unusable_o}, 0);
			for (n = 0; n < 40 && pf_o.valid !== 1'b0; n++)
			begin
				@(posedge core_clk_i);
				#1;
			end
			over(40);
		end
		@(posedge core_clk_i);
		#1;
		check("pf left", exp_q.size(), 0);
		check("coherent", coh_seen, coh_exp);
		$display("Test prefetch done");
		test_done();
	end
endmodule : or_pause_pairmerge_prefetch_exec_bench
